/* File: logic/harvester_path_pkg.sv */
package harvester_path_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] PATH_CFG_IDX = 8'h18;
  localparam logic [7:0] THERM_CFG_IDX = 8'h19;
  localparam logic [7:0] CTRL_IDX = 8'h30;
  localparam logic [7:0] STATUS_IDX = 8'h31;

  // field positions in the path configuration register
  localparam int unsigned PATH_SEL_LSB = 6;
  localparam int unsigned RECHG_LSB = 4;
  localparam int unsigned THR_LSB = 0;

  // field positions in the thermal configuration register
  localparam int unsigned INHIBIT_BIT = 6;
  localparam int unsigned WARM_CUT_LSB = 4;
  localparam int unsigned ROOM_CUT_LSB = 2;
  localparam int unsigned COOL_CUT_LSB = 0;

  // field positions in the control register
  localparam int unsigned HARVEST_EN_BIT = 0;
  localparam int unsigned THM_SEL_LSB = 1;

  // values after reset
  localparam logic [7:0] PATH_CFG_RST = 8'h00;
  localparam logic [6:0] THERM_CFG_RST = 7'h00;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // millivolt arithmetic of the thresholds
  localparam int unsigned MV_W = 13;
  localparam logic [12:0] REG_BASE_MV = 13'h0fd2;
  localparam logic [12:0] STEP_MV = 13'h0032;
  localparam logic [12:0] RECHG_BASE_MV = 13'h0046;
  localparam logic [3:0] REG_MAX_CODE = 4'hb;

  // input synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    PATH_DIRECT = 2'h0,
    PATH_AUTO = 2'h1,
    PATH_DIODE = 2'h2,
    PATH_RSVD = 2'h3
  } path_sel_t;

  typedef enum logic [1:0] {
    ZONE_NONE = 2'h0,
    ZONE_COOL = 2'h1,
    ZONE_ROOM = 2'h2,
    ZONE_WARM = 2'h3
  } zone_t;

endpackage

/* File: logic/harvester_threshold_calc.sv */
`timescale 1ns/1ps
module harvester_threshold_calc #(
  parameter int MV_W = 13
) (
  input wire logic [3:0] i_reg_code,
  input wire logic [1:0] i_cut_code,
  input wire logic [1:0] i_rechg_code,
  output logic [MV_W-1:0] o_thr_mv,
  output logic [MV_W-1:0] o_return_mv
);

  // base plus n steps of 50 mV
  function automatic logic [MV_W-1:0] step_mv(input logic [MV_W-1:0] base, input logic [3:0] n);
    return MV_W'(base + MV_W'(n) * MV_W'(harvester_path_pkg::STEP_MV));
  endfunction

  logic [3:0] code;
  logic [MV_W-1:0] cut_mv;
  logic [MV_W-1:0] hyst_mv;

  // reserved threshold codes clamp to the top setting rather than wrap upward
  always_comb
  begin
    code = (i_reg_code > harvester_path_pkg::REG_MAX_CODE) ?
      harvester_path_pkg::REG_MAX_CODE : i_reg_code;
    cut_mv = step_mv('0, {2'h0, ~i_cut_code});
    hyst_mv = step_mv(MV_W'(harvester_path_pkg::RECHG_BASE_MV), {2'h0, i_rechg_code});
    o_thr_mv = MV_W'(step_mv(MV_W'(harvester_path_pkg::REG_BASE_MV), code) - cut_mv);
    o_return_mv = MV_W'(o_thr_mv - hyst_mv);
  end

endmodule

/* File: logic/harvester_path_control.sv */
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module harvester_path_control (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [12:0] i_vbat_mv,
  input wire logic i_charger_input,
  input wire logic [1:0] i_zone,
  output logic o_path_ideal_diode,
  output logic o_charger_owns_path,
  output logic o_harvester_disable_output,
  output logic [12:0] o_threshold_mv
);

  localparam int SS = harvester_path_pkg::SYNC_STAGES;

  // decode a bus address into a register index; misaligned or high addresses miss
  function automatic logic [8:0] decode(input logic [31:0] addr);
    logic hit;
    hit = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0);
    return {hit, addr[9:2]};
  endfunction

  // bus and register state
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_idx_q, wr_idx_d;
  logic [7:0] path_cfg_q, path_cfg_d;
  logic [6:0] therm_cfg_q, therm_cfg_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [8:0] dec;
  logic accept;

  // synchronised inputs
  logic [SS-1:0] chg_sync_q;
  logic [1:0] zone_sync_q [SS];
  logic [12:0] vbat_sync_q [SS];
  logic chg_s;
  harvester_path_pkg::zone_t zone_s;
  logic [12:0] vbat_s;

  // path state
  logic latch_q, latch_d;
  logic ideal_q, ideal_d;
  logic owns_q, owns_d;
  logic hdis_q, hdis_d;
  logic [12:0] thr_out_q;
  logic [12:0] thr_mv, ret_mv;

  // decoded configuration
  harvester_path_pkg::path_sel_t sel;
  logic [1:0] thm_sel;
  logic en, inhibit_bit, mon_on, zone_ok, inhibit_cond, force_diode;
  logic [1:0] cut_code;

  assign chg_s = chg_sync_q[SS-1];
  assign zone_s = harvester_path_pkg::zone_t'(zone_sync_q[SS-1]);
  assign vbat_s = vbat_sync_q[SS-1];
  assign sel = harvester_path_pkg::path_sel_t'(path_cfg_q[harvester_path_pkg::PATH_SEL_LSB +: 2]);
  assign thm_sel = ctrl_q[harvester_path_pkg::THM_SEL_LSB +: 2];
  assign en = ctrl_q[harvester_path_pkg::HARVEST_EN_BIT];
  assign inhibit_bit = therm_cfg_q[harvester_path_pkg::INHIBIT_BIT];

  // bus next state: zero-wait slave, read data captured in the address phase
  always_comb
  begin
    dec = decode(i_haddr);
    accept = i_hsel && i_htrans[1] && i_hready;
    wr_pend_d = accept && i_hwrite;
    wr_idx_d = accept ? dec[7:0] : wr_idx_q;
    path_cfg_d = path_cfg_q;
    therm_cfg_d = therm_cfg_q;
    ctrl_d = ctrl_q;
    hrdata_d = 32'h00000000;
    // write data arrives in the data phase, one cycle after the address
    if (wr_pend_q)
    begin
      unique case (wr_idx_q)
        harvester_path_pkg::PATH_CFG_IDX: path_cfg_d = i_hwdata[7:0];
        harvester_path_pkg::THERM_CFG_IDX: therm_cfg_d = i_hwdata[6:0];
        harvester_path_pkg::CTRL_IDX: ctrl_d = i_hwdata[2:0];
        default: ; // status is read-only, unmapped writes are dropped
      endcase
    end
    if (accept && !i_hwrite && dec[8])
    begin
      unique case (dec[7:0])
        harvester_path_pkg::PATH_CFG_IDX: hrdata_d = {24'h000000, path_cfg_q};
        harvester_path_pkg::THERM_CFG_IDX: hrdata_d = {25'h0000000, therm_cfg_q};
        harvester_path_pkg::CTRL_IDX: hrdata_d = {29'h00000000, ctrl_q};
        harvester_path_pkg::STATUS_IDX:
          hrdata_d = {28'h0000000, latch_q, owns_q, hdis_q, ideal_q};
        default: hrdata_d = 32'h00000000; // unmapped reads return zero
      endcase
    end
  end

  // an address miss clears the pending write flag so it cannot alias a register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      path_cfg_q <= harvester_path_pkg::PATH_CFG_RST;
      therm_cfg_q <= harvester_path_pkg::THERM_CFG_RST;
      ctrl_q <= harvester_path_pkg::CTRL_RST;
      hrdata_q <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= wr_pend_d && dec[8];
      wr_idx_q <= wr_idx_d;
      path_cfg_q <= path_cfg_d;
      therm_cfg_q <= therm_cfg_d;
      ctrl_q <= ctrl_d;
      hrdata_q <= hrdata_d;
    end
  end

  // two-stage synchronisers; the ADC word is assumed to hold steady between updates
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      chg_sync_q <= '0;
      for (int i = 0; i < SS; i++)
      begin
        zone_sync_q[i] <= 2'h0;
        vbat_sync_q[i] <= 13'h0000;
      end
    end
    else
    begin
      chg_sync_q <= {chg_sync_q[SS-2:0], i_charger_input};
      zone_sync_q[0] <= i_zone;
      vbat_sync_q[0] <= i_vbat_mv;
      for (int i = 1; i < SS; i++)
      begin
        zone_sync_q[i] <= zone_sync_q[i-1];
        vbat_sync_q[i] <= vbat_sync_q[i-1];
      end
    end
  end

  harvester_threshold_calc #(
    .MV_W(13)
  ) u_calc (
    .i_reg_code(path_cfg_q[harvester_path_pkg::THR_LSB +: 4]),
    .i_cut_code(cut_code),
    .i_rechg_code(path_cfg_q[harvester_path_pkg::RECHG_LSB +: 2]),
    .o_thr_mv(thr_mv),
    .o_return_mv(ret_mv)
  );

  // zone decisions and transistor mode selection, in priority order
  always_comb
  begin
    mon_on = thm_sel != 2'h0;
    cut_code = 2'h3;
    if (mon_on)
    begin
      unique case (zone_s)
        harvester_path_pkg::ZONE_COOL:
          cut_code = therm_cfg_q[harvester_path_pkg::COOL_CUT_LSB +: 2];
        harvester_path_pkg::ZONE_ROOM:
          cut_code = therm_cfg_q[harvester_path_pkg::ROOM_CUT_LSB +: 2];
        harvester_path_pkg::ZONE_WARM:
          cut_code = therm_cfg_q[harvester_path_pkg::WARM_CUT_LSB +: 2];
        harvester_path_pkg::ZONE_NONE: cut_code = 2'h3;
      endcase
    end
    unique case (thm_sel)
      2'h1: zone_ok = (zone_s == harvester_path_pkg::ZONE_COOL) ||
                      (zone_s == harvester_path_pkg::ZONE_ROOM);
      2'h2: zone_ok = (zone_s == harvester_path_pkg::ZONE_ROOM) ||
                      (zone_s == harvester_path_pkg::ZONE_WARM);
      2'h3: zone_ok = zone_s != harvester_path_pkg::ZONE_NONE;
      2'h0: zone_ok = 1'b1;
    endcase
    inhibit_cond = !chg_s && en && mon_on && !zone_ok;
    force_diode = inhibit_cond && inhibit_bit;
    // hysteresis latch only lives in auto mode; leaving auto restarts it
    latch_d = 1'b0;
    if (sel == harvester_path_pkg::PATH_AUTO)
    begin
      if (vbat_s > thr_mv)
        latch_d = 1'b1;
      else if (vbat_s < ret_mv)
        latch_d = 1'b0;
      else
        latch_d = latch_q;
    end
    owns_d = chg_s;
    ideal_d = 1'b0;
    if (chg_s)
      ideal_d = 1'b0;
    else if (!en)
      ideal_d = 1'b0;
    else if (force_diode)
      ideal_d = 1'b1;
    else
    begin
      unique case (sel)
        harvester_path_pkg::PATH_DIRECT: ideal_d = 1'b0;
        harvester_path_pkg::PATH_AUTO: ideal_d = latch_d;
        harvester_path_pkg::PATH_DIODE: ideal_d = 1'b1;
        harvester_path_pkg::PATH_RSVD: ideal_d = 1'b0; // reserved acts as direct
      endcase
    end
    hdis_d = en && (chg_s || (inhibit_cond && !inhibit_bit));
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      latch_q <= 1'b0;
      ideal_q <= 1'b0;
      owns_q <= 1'b0;
      hdis_q <= 1'b0;
      thr_out_q <= 13'h0000;
    end
    else
    begin
      latch_q <= latch_d;
      ideal_q <= ideal_d;
      owns_q <= owns_d;
      hdis_q <= hdis_d;
      thr_out_q <= thr_mv;
    end
  end

  // every output but hreadyout and hresp straight from a flip-flop; those two are constants, response is always OKAY
  assign o_hrdata = hrdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_path_ideal_diode = ideal_q;
  assign o_charger_owns_path = owns_q;
  assign o_harvester_disable_output = hdis_q;
  assign o_threshold_mv = thr_out_q;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic run;
  assign run = en && !chg_s && !force_diode;

  a_sel_direct: assert property (
    run && sel == harvester_path_pkg::PATH_DIRECT |=> !o_path_ideal_diode)
    else $error("direct path not forced");

  a_auto_rise: assert property (
    run && sel == harvester_path_pkg::PATH_AUTO && vbat_s > thr_mv |=> o_path_ideal_diode)
    else $error("auto mode missed diode above threshold");

  a_auto_hold: assert property (
    run && sel == harvester_path_pkg::PATH_AUTO && latch_q && vbat_s >= ret_mv
    |=> o_path_ideal_diode)
    else $error("hysteresis not held");

  a_auto_fall: assert property (
    run && sel == harvester_path_pkg::PATH_AUTO && vbat_s < ret_mv |=> !o_path_ideal_diode)
    else $error("auto mode stayed diode below return");

  a_sel_diode: assert property (
    run && sel == harvester_path_pkg::PATH_DIODE |=> o_path_ideal_diode)
    else $error("diode not forced");

  a_no_harvest: assert property (
    !en && !chg_s |=> !o_path_ideal_diode && !o_harvester_disable_output)
    else $error("disabled interaction not direct");

  a_charger_owns: assert property (
    chg_s |=> o_charger_owns_path && !o_path_ideal_diode)
    else $error("charger does not own path");

  a_rechg_gap: assert property (
    13'(thr_mv - ret_mv) == 13'(harvester_path_pkg::RECHG_BASE_MV +
      13'(path_cfg_q[harvester_path_pkg::RECHG_LSB +: 2]) * harvester_path_pkg::STEP_MV))
    else $error("recharge hysteresis wrong");

  a_thr_code: assert property (
    !mon_on && path_cfg_q[3:0] <= harvester_path_pkg::REG_MAX_CODE |=>
    o_threshold_mv == 13'(harvester_path_pkg::REG_BASE_MV +
      13'($past(path_cfg_q[3:0])) * harvester_path_pkg::STEP_MV))
    else $error("threshold code decode wrong");

  a_hdis_charger: assert property (
    en && chg_s |=> o_harvester_disable_output)
    else $error("harvester not disabled with charger");

  a_zone_keep: assert property (
    inhibit_cond && !inhibit_bit && sel == harvester_path_pkg::PATH_DIRECT
    |=> o_harvester_disable_output && !o_path_ideal_diode)
    else $error("zone inhibit 0 misbehaves");

  a_zone_force: assert property (
    inhibit_cond && inhibit_bit |=> !o_harvester_disable_output && o_path_ideal_diode)
    else $error("zone inhibit 1 misbehaves");

  a_warm_cut: assert property (
    mon_on && zone_s == harvester_path_pkg::ZONE_WARM && path_cfg_q[3:0] == 4'h0 &&
    therm_cfg_q[harvester_path_pkg::WARM_CUT_LSB +: 2] == 2'h0 |=> o_threshold_mv == 13'h0f3c)
    else $error("warm cut not applied");

  a_zone_perm: assert property (
    en && !chg_s && thm_sel == 2'h1 && zone_s == harvester_path_pkg::ZONE_WARM &&
    !inhibit_bit |=> o_harvester_disable_output)
    else $error("warm zone not inhibited under select 01");

  a_sync_lag: assert property (
    !$past(i_sys_rst, 3) |-> o_charger_owns_path == $past(i_charger_input, 3))
    else $error("charger sync latency wrong");

  c_auto_diode: cover property (run && sel == harvester_path_pkg::PATH_AUTO ##1
    o_path_ideal_diode ##1 !o_path_ideal_diode);
  c_zone_force: cover property (force_diode ##1 o_path_ideal_diode);
  c_charger: cover property (chg_s && en ##1 o_harvester_disable_output);

endmodule

/* File: tb/harvester_env_model.sv */
`timescale 1ns/1ps
// battery, charger input and temperature zone as the control block sees them
module harvester_env_model (
  input wire logic i_sys_clk,
  output logic [12:0] o_vbat_mv,
  output logic o_charger_input,
  output logic [1:0] o_zone
);
  // quiet battery, no charger, zone outside the permitted band
  initial
  begin
    o_vbat_mv = 13'h0e10;
    o_charger_input = 1'b0;
    o_zone = 2'h0;
  end

  // levels move just after an edge, then hold past the three-edge synchroniser delay
  task automatic apply(input logic [12:0] mv, input logic chg, input logic [1:0] zn);
    @(posedge i_sys_clk);
    o_vbat_mv <= mv;
    o_charger_input <= chg;
    o_zone <= zn;
    repeat (5) @(posedge i_sys_clk);
  endtask
endmodule

/* File: tb/harvester_path_control_test.sv */
`timescale 1ns/1ps
module harvester_path_control_test;
  logic sys_clk, sys_rst, hsel, hwrite, hready, hresp, charger, diode, owns, hdis, p;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, zone, k;
  logic [12:0] vbat_mv, thr_mv;
  logic [2:0] ex;
  int errors, cmp_count, cycles, s, z, r, c, hy;

  harvester_path_control dut_u (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_vbat_mv(vbat_mv), .i_charger_input(charger), .i_zone(zone),
    .o_path_ideal_diode(diode), .o_charger_owns_path(owns),
    .o_harvester_disable_output(hdis), .o_threshold_mv(thr_mv)
  );

  harvester_env_model env_u (
    .i_sys_clk(sys_clk), .o_vbat_mv(vbat_mv), .o_charger_input(charger), .o_zone(zone)
  );

  always #5 sys_clk = ~sys_clk;

  // hang guard: the whole sequence needs under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("unexpected timeout expected 0 seen %0d", cycles);
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one single transfer; the master waits for hready at both phases
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // three edges let a new setting reach the outputs
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, {24'h0, v});
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(name, exp, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wpath(input logic [7:0] v);
    wr(harvester_path_pkg::PATH_CFG_IDX, v);
  endtask

  task automatic wtherm(input logic [7:0] v);
    wr(harvester_path_pkg::THERM_CFG_IDX, v);
  endtask

  task automatic wctrl(input logic [2:0] v);
    wr(harvester_path_pkg::CTRL_IDX, {5'h0, v});
  endtask

  task automatic outs(input logic [2:0] exp);
    chk("owns_disable_diode", {29'h0, exp}, {29'h0, owns, hdis, diode});
  endtask

  initial
  begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // registers clear on reset; unmapped and read-only places hold nothing writable
    rchk("path cfg", harvester_path_pkg::PATH_CFG_IDX, 32'h0);
    rchk("therm cfg", harvester_path_pkg::THERM_CFG_IDX, 32'h0);
    rchk("ctrl", harvester_path_pkg::CTRL_IDX, 32'h0);
    wpath(8'hff);
    rchk("path cfg", harvester_path_pkg::PATH_CFG_IDX, 32'hff);
    wtherm(8'hff);
    rchk("therm cfg", harvester_path_pkg::THERM_CFG_IDX, 32'h7f);
    wr(8'h20, 8'hff);
    rchk("unmapped", 8'h20, 32'h0);
    wr(harvester_path_pkg::STATUS_IDX, 8'hff);
    rchk("status", harvester_path_pkg::STATUS_IDX, 32'h0);
    // forced direct path even with a full battery
    wtherm(8'h00);
    wctrl(3'h1);
    wpath(8'h00);
    env_u.apply(13'd4500, 1'b0, 2'h0);
    outs(3'b000);
    // every threshold code; reserved codes sit at the top value
    for (c = 0; c < 16; c++)
    begin
      wpath({4'h4, 4'(c)});
      chk("threshold", 32'(4050 + 50 * (c > 11 ? 11 : c)), {19'h0, thr_mv});
    end
    // auto mode: strict threshold crossing, then hysteresis hold and release
    // drop the battery first, or the 4.15 V setting would latch diode at once
    env_u.apply(13'd3600, 1'b0, 2'h0);
    for (r = 0; r < 4; r++)
    begin
      hy = 70 + 50 * r;
      wpath({2'b01, 2'(r), 4'h2});
      env_u.apply(13'd4150, 1'b0, 2'h0);
      outs(3'b000);
      env_u.apply(13'd4151, 1'b0, 2'h0);
      outs(3'b001);
      env_u.apply(13'(4150 - hy), 1'b0, 2'h0);
      outs(3'b001);
      env_u.apply(13'(4149 - hy), 1'b0, 2'h0);
      outs(3'b000);
    end
    // forced diode, reserved code, and interaction switched off
    wpath(8'h80);
    outs(3'b001);
    wpath(8'hc0);
    outs(3'b000);
    wpath(8'h80);
    wctrl(3'h0);
    outs(3'b000);
    // charger present takes the transistor and stops the harvester when enabled
    wctrl(3'h1);
    env_u.apply(13'd3600, 1'b1, 2'h0);
    outs(3'b110);
    rchk("status", harvester_path_pkg::STATUS_IDX, 32'h6);
    wctrl(3'h0);
    outs(3'b100);
    // zone inhibit against every monitor select and zone
    wpath(8'h00);
    for (s = 0; s < 4; s++)
    begin
      wctrl({2'(s), 1'b1});
      for (r = 0; r < 2; r++)
      begin
        wtherm({1'b0, 1'(r), 6'h3f});
        for (z = 0; z < 4; z++)
        begin
          env_u.apply(13'd3600, 1'b0, 2'(z));
          p = (s == 0) || (z != 0 && (s == 3 || (s == 1 && z != 3) || (s == 2 && z != 1)));
          ex = {1'b0, !p && r == 0, !p && r == 1};
          outs(ex);
        end
      end
    end
    // zone cuts; distinct codes per field catch swapped fields
    wctrl(3'h7);
    for (c = 0; c < 4; c++)
    begin
      wtherm({2'h0, 2'(c), 2'(c + 1), 2'(c + 2)});
      for (z = 0; z < 4; z++)
      begin
        env_u.apply(13'd3600, 1'b0, 2'(z));
        k = 2'(c + 3 - z);
        hy = (z == 0 || k == 2'h3) ? 0 : 150 - 50 * k;
        chk("threshold", 32'(4050 - hy), {19'h0, thr_mv});
      end
    end
    conclude();
  end
endmodule
